// ==== include/eec_regs.vh ====
// Constants for the two-wire serial byte memory core with per-group error correction.
// Assumes a 250 MHz core clock; all bus pins arrive asynchronously to it.
// Operation
// (RULE_01) Three strap inputs give the 3-bit target address; eight addresses selectable.
// (RULE_02) Respond only when received address bits match the strap value.
// (RULE_03) An unconnected strap reads as low.
// (RULE_04) Data line is open drain: sampled as input, only ever pulled low.
// (RULE_05) Write protect high blocks memory writes; low allows writes everywhere.
// (RULE_06) Unwritten memory reads back as all ones.
// (RULE_07) Six check bits are kept with every aligned four-byte group.
// (RULE_08) Reads correct any single flipped bit in a group before delivery.
// (RULE_09) Partial group writes reprogram the whole group with fresh check bits.
// (RULE_10) Controller should write whole aligned groups for best wear life.
// (RULE_11) Serial bits and conditions are processed on both bus clock edges; code samples bits on rising edges only, conditions while the clock is high.
// (RULE_12) Upper four target address bits are the fixed family code 1010.
// (RULE_13) On address match, pull data low during the ninth clock.
// (RULE_14) While write protected, data bytes for writing are not acknowledged.
// (RULE_15) During an internal programming cycle, no transfer is acknowledged.
// (RULE_16) Programming is a busy interval of configurable length, at most the write time.
// (RULE_17) Array is 65536 bytes, 16-bit address, in four-byte correction groups.
`ifndef EEC_REGS_VH
`define EEC_REGS_VH

`define EEC_FAMILY_CODE 4'hA
`define EEC_ADDR_W 16
`define EEC_GROUP_W 14
`define EEC_GROUPS 16384
`define EEC_CHK_W 6
`define EEC_ERASED_WORD 32'hFFFFFFFF
`define EEC_CLK_PERIOD_PS 4000
`define EEC_T_WR_MS 5
// Longest time, so rounded down to whole clock cycles; kept inside 32-bit integer range
`define EEC_WR_CYCLES ((`EEC_T_WR_MS * 1000000) / (`EEC_CLK_PERIOD_PS / 1000))

`endif

// ==== core/eec_ecc.v ====
// Single-error-correcting code over one 32-bit group with six check bits.
// Purely combinational; encode and correct share one parity network.
`timescale 1ns/1ps
`include "eec_regs.vh"

module eec_ecc
(
  input wire [31:0] data_in,
  input wire [`EEC_CHK_W-1:0] chk_in,
  output reg [`EEC_CHK_W-1:0] chk_out,
  output reg [31:0] data_out
);

  integer p;
  integer j;
  integer k;
  reg [`EEC_CHK_W-1:0] syn;
  reg [31:0] fix;

  // Data bits occupy the non-power-of-two positions 3..38 of a Hamming word
  always @*
  begin
    chk_out = {`EEC_CHK_W{1'b0}};
    fix = 32'h00000000;
    k = 0;
    for (p = 1; p <= 38; p = p + 1)
    begin
      if ((p & (p - 1)) != 0)
      begin
        for (j = 0; j < `EEC_CHK_W; j = j + 1)
        begin
          if (((p >> j) & 1) == 1)
            chk_out[j] = chk_out[j] ^ data_in[k]; // see RULE_07
        end
        k = k + 1;
      end
    end
    syn = chk_out ^ chk_in;
    k = 0;
    for (p = 1; p <= 38; p = p + 1)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (syn == p[5:0])
          fix[k] = 1'b1; // see RULE_08
        k = k + 1;
      end
    end
    data_out = data_in ^ fix;
  end

endmodule

// ==== core/eec_core.v ====
// Target side of a two-wire serial byte memory with per-group error correction.
// Assumes bus pins are asynchronous; pads provide strap pull-downs and open-drain drive.
`timescale 1ns/1ps
`include "eec_regs.vh"

module eec_core
#(
  parameter [31:0] WR_CYCLES = `EEC_WR_CYCLES
)
(
  input wire ref_clk,
  input wire nrst,
  input wire scl,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  input wire addr_strap_bit0,
  input wire addr_strap_bit1,
  input wire addr_strap_bit2,
  input wire write_protect,
  output reg program_busy
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_DEV = 3'h1;
  localparam [2:0] ST_AHI = 3'h2;
  localparam [2:0] ST_ALO = 3'h3;
  localparam [2:0] ST_WDAT = 3'h4;
  localparam [2:0] ST_RDAT = 3'h5;
  localparam [1:0] E_IDLE = 2'h0;
  localparam [1:0] E_RD = 2'h1;
  localparam [1:0] E_WR = 2'h2;

  reg scl_m, scl_s, scl_d;
  reg sda_m, sda_s, sda_d;
  reg [2:0] strap_m, strap_s;
  reg wp_m, wp_s;
  reg [2:0] st;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg pull_low;
  reg rnw;
  reg mnack;
  reg wrote;
  reg [`EEC_ADDR_W-1:0] ptr;
  reg [31:0] busy_cnt;
  reg [23:0] bq [0:1];
  reg [1:0] bq_cnt;
  reg bq_wp, bq_rp;
  reg [1:0] eng_st;
  reg [`EEC_ADDR_W-1:0] eng_addr;
  reg [7:0] eng_byte;
  reg [37:0] mem [0:`EEC_GROUPS-1];
  reg [37:0] mem_q;
  reg [31:0] merged;
  integer gi;

  wire [`EEC_CHK_W-1:0] enc_chk;
  wire [31:0] dec_data;
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s; // see RULE_11
  wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;
  wire bq_in_ready = (bq_cnt != 2'd2);
  wire bq_out_valid = (bq_cnt != 2'd0);
  wire bq_pop = bq_out_valid && (eng_st == E_IDLE);
  wire dev_match = (shreg[7:1] == {`EEC_FAMILY_CODE, strap_s}); // see RULE_02, RULE_12
  wire wr_ok = !wp_s && bq_in_ready; // see RULE_05
  wire do_push = scl_fall && (st == ST_WDAT) && (bit_cnt == 4'd8) && wr_ok;
  wire [`EEC_GROUP_W-1:0] rd_grp = (eng_st != E_IDLE) ? eng_addr[15:2] : ptr[15:2];
  wire [7:0] stored_byte = dec_data[{ptr[1:0], 3'b000} +: 8];
  wire [7:0] rd_byte = ~stored_byte;

  // Only ever pulled low; high comes from the bus pull-up
  assign sda_out = 1'b0; // see RULE_04
  assign sda_oe_n = ~pull_low; // see RULE_04

  // Straps are sampled like any pin; open ones read low via the pad pull-down
  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      strap_m <= 3'h0;
      strap_s <= 3'h0;
      wp_m <= 1'b0;
      wp_s <= 1'b0;
    end
    else
    begin
      scl_m <= scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      strap_m <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}; // see RULE_01, RULE_03
      strap_s <= strap_m;
      wp_m <= write_protect;
      wp_s <= wp_m;
    end
  end

  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      st <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      pull_low <= 1'b0;
      rnw <= 1'b0;
      mnack <= 1'b0;
      wrote <= 1'b0;
      ptr <= {`EEC_ADDR_W{1'b0}};
      busy_cnt <= 32'h00000000;
      program_busy <= 1'b0;
    end
    else
    begin
      program_busy <= (busy_cnt != 32'h00000000) || bq_out_valid || (eng_st != E_IDLE);
      if (busy_cnt != 32'h00000000)
        busy_cnt <= busy_cnt - 32'h00000001; // see RULE_16
      if (start_cond)
      begin
        st <= ST_DEV;
        bit_cnt <= 4'h0;
        pull_low <= 1'b0;
      end
      else if (stop_cond)
      begin
        st <= ST_IDLE;
        pull_low <= 1'b0;
        wrote <= 1'b0;
        if (wrote)
          busy_cnt <= WR_CYCLES; // see RULE_16
      end
      else if (scl_rise && st != ST_IDLE)
      begin
        // In read state the same shift moves the next bit to the top
        if (bit_cnt < 4'd8)
          shreg <= {shreg[6:0], sda_s};
        if (bit_cnt == 4'd8)
          mnack <= sda_s;
        bit_cnt <= bit_cnt + 4'h1;
      end
      else if (scl_fall)
      begin
        case (st)
          ST_DEV:
          begin
            if (bit_cnt == 4'd8)
            begin
              if (dev_match && !program_busy)
              begin
                pull_low <= 1'b1; // see RULE_13, RULE_15
                rnw <= shreg[0];
              end
              else
                st <= ST_IDLE; // see RULE_02, RULE_15
            end
            else if (bit_cnt == 4'd9)
            begin
              bit_cnt <= 4'h0;
              if (rnw)
              begin
                st <= ST_RDAT;
                shreg <= rd_byte;
                pull_low <= ~rd_byte[7];
              end
              else
              begin
                st <= ST_AHI;
                pull_low <= 1'b0;
              end
            end
          end
          ST_AHI, ST_ALO, ST_WDAT:
          begin
            if (bit_cnt == 4'd8)
            begin
              if (st == ST_AHI)
              begin
                ptr[15:8] <= shreg;
                pull_low <= 1'b1;
              end
              else if (st == ST_ALO)
              begin
                ptr[7:0] <= shreg;
                pull_low <= 1'b1;
              end
              else if (wr_ok)
              begin
                // Page writes wrap within the low seven address bits
                ptr <= {ptr[15:7], ptr[6:0] + 7'h01};
                pull_low <= 1'b1;
                wrote <= 1'b1;
              end
              else
                pull_low <= 1'b0; // see RULE_14
            end
            else if (bit_cnt == 4'd9)
            begin
              bit_cnt <= 4'h0;
              pull_low <= 1'b0;
              if (st == ST_AHI)
                st <= ST_ALO;
              else
                st <= ST_WDAT;
            end
          end
          ST_RDAT:
          begin
            if (bit_cnt < 4'd8)
              pull_low <= ~shreg[7];
            else if (bit_cnt == 4'd8)
            begin
              pull_low <= 1'b0;
              ptr <= ptr + 16'h0001;
            end
            else
            begin
              bit_cnt <= 4'h0;
              if (mnack)
              begin
                st <= ST_IDLE;
                pull_low <= 1'b0;
              end
              else
              begin
                shreg <= rd_byte; // see RULE_08
                pull_low <= ~rd_byte[7];
              end
            end
          end
          default:
          begin
            pull_low <= 1'b0;
          end
        endcase
      end
    end
  end

  // Two-entry buffer between the bus side and the merge engine
  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      bq_cnt <= 2'd0;
      bq_wp <= 1'b0;
      bq_rp <= 1'b0;
    end
    else
    begin
      if (do_push)
      begin
        bq[bq_wp] <= {ptr, shreg};
        bq_wp <= ~bq_wp;
      end
      if (bq_pop)
        bq_rp <= ~bq_rp;
      if (do_push && !bq_pop)
        bq_cnt <= bq_cnt + 2'd1;
      else if (bq_pop && !do_push)
        bq_cnt <= bq_cnt - 2'd1;
    end
  end

  // Engine: read the group, correct it, splice the byte, re-encode, write back
  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      eng_st <= E_IDLE;
      eng_addr <= {`EEC_ADDR_W{1'b0}};
      eng_byte <= 8'h00;
    end
    else
    begin
      case (eng_st)
        E_IDLE:
        begin
          if (bq_pop)
          begin
            eng_addr <= bq[bq_rp][23:8];
            eng_byte <= bq[bq_rp][7:0];
            eng_st <= E_RD;
          end
        end
        // Wait one cycle so mem_q holds this group before the merge
        E_RD:
        begin
          eng_st <= E_WR;
        end
        default:
        begin
          eng_st <= E_IDLE;
        end
      endcase
    end
  end

  always @*
  begin
    merged = dec_data;
    merged[{eng_addr[1:0], 3'b000} +: 8] = ~eng_byte; // see RULE_09
  end

  // Data is held inverted so a cleared array is the valid all-zero codeword that reads back as all ones
  initial
  begin
    for (gi = 0; gi < `EEC_GROUPS; gi = gi + 1)
      mem[gi] = {{`EEC_CHK_W{1'b0}}, ~`EEC_ERASED_WORD}; // see RULE_06
  end

  // The write lands one cycle after the read of the same group
  always @(posedge ref_clk)
  begin
    mem_q <= mem[rd_grp]; // see RULE_17
    if (eng_st == E_WR)
      mem[eng_addr[15:2]] <= {enc_chk, merged}; // see RULE_07, RULE_09
  end

  eec_ecc u_dec
  (
    .data_in(mem_q[31:0]),
    .chk_in(mem_q[37:32]),
    .chk_out(),
    .data_out(dec_data)
  );

  eec_ecc u_enc
  (
    .data_in(merged),
    .chk_in({`EEC_CHK_W{1'b0}}),
    .chk_out(enc_chk),
    .data_out()
  );

endmodule

// ==== bench/eec_core_checker.sv ====
// Port checker for the serial byte memory core.
// Assumes the bind below and a short programming interval.
`timescale 1ns/1ps
module eec_core_checker
#(
  parameter [31:0] WR_CYCLES = 32'h32
)
(
  input wire ref_clk,
  input wire nrst,
  input wire scl,
  input wire sda_out,
  input wire sda_oe_n,
  input wire write_protect,
  input wire program_busy
);
  reg [31:0] busy_len;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  always @(posedge ref_clk)
    if (!nrst || !program_busy)
      busy_len <= 32'h0;
    else
      busy_len <= busy_len + 32'h1;
  drain_only_a: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  reset_idle_a: assert property ($rose(nrst) |-> sda_oe_n && !program_busy)
    else $error("not idle after reset");
  oe_low_scl_a: assert property ($changed(sda_oe_n) |-> !scl)
    else $error("output moved while clock high");
  ack_hold_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
    else $error("pull-down too short");
  busy_quiet_a: assert property (program_busy [*8] |-> sda_oe_n)
    else $error("driving while programming");
  busy_start_a: assert property ($rose(program_busy) |-> !write_protect)
    else $error("busy began while protected");
  busy_end_a: assert property (busy_len <= WR_CYCLES + 32'h10)
    else $error("busy never ended");
  busy_len_a: assert property ($fell(program_busy) && busy_len > 32'h8 |->
    busy_len + 32'h2 >= WR_CYCLES && busy_len <= WR_CYCLES + 32'h8)
    else $error("busy length wrong");
endmodule

bind eec_core eec_core_checker #(.WR_CYCLES(WR_CYCLES)) u_chk
(
  .ref_clk(ref_clk),
  .nrst(nrst),
  .scl(scl),
  .sda_out(sda_out),
  .sda_oe_n(sda_oe_n),
  .write_protect(write_protect),
  .program_busy(program_busy)
);

// ==== bench/eec_mstr.sv ====
// Bus controller model that drives the two-wire link.
// Assumes a pull-up on the data wire; all moves on core falling edges.
`timescale 1ns/1ps
`include "eec_regs.vh"
module eec_mstr
(
  input wire ref_clk,
  input wire sda_oe_n,
  input wire sda_out,
  output reg scl,
  output wire sda_in
);
  reg sda_drv;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Pull-up wins unless a party pulls low
  assign sda_in = sda_drv & (sda_oe_n | sda_out);
  // 128 ns per bit: nearest to 125 ns on the 16 ns grid of four equal whole-cycle quarters
  task q;
    repeat (8) @(negedge ref_clk);
  endtask
  task start;
  begin
    sda_drv = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_drv = 1'b0;
    q;
    scl = 1'b0;
    q;
  end
  endtask
  task stop;
  begin
    sda_drv = 1'b0;
    q;
    scl = 1'b1;
    q;
    sda_drv = 1'b1;
    q;
  end
  endtask
  // Data moves only while the clock is low
  task xfer(input [7:0] d, input a, output [7:0] r, output k);
    reg [8:0] s;
    integer n;
  begin
    s = {d, a};
    for (n = 8; n >= 0; n = n - 1)
    begin
      sda_drv = s[n];
      q;
      scl = 1'b1;
      q;
      s[n] = sda_in;
      q;
      scl = 1'b0;
      q;
    end
    r = s[8:1];
    k = s[0];
  end
  endtask
  task dev(input [2:0] a, input rw, output k);
    reg [7:0] r;
    xfer({`EEC_FAMILY_CODE, a, rw}, 1'b1, r, k);
  endtask
endmodule

// ==== bench/eec_core_tb.sv ====
// Bench for the serial byte memory core, driven through the controller model.
// Assumes the checker binds itself to the core.
`timescale 1ns/1ps
module eec_core_tb;
  reg ref_clk = 1'b0;
  reg nrst = 1'b0;
  reg [2:0] strap = 3'h0;
  reg write_protect = 1'b0;
  wire scl;
  wire sda_in;
  wire sda_out;
  wire sda_oe_n;
  wire program_busy;
  integer failures = 0;
  integer samples_checked = 0;
  integer i;
  integer j;
  reg k;
  reg [7:0] r;
  reg [63:0] rb;
  always #2 ref_clk = ~ref_clk;
  eec_core #(.WR_CYCLES(32'h7D0)) u_dut
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .scl(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]),
    .addr_strap_bit2(strap[2]),
    .write_protect(write_protect),
    .program_busy(program_busy)
  );
  eec_mstr u_mst
  (
    .ref_clk(ref_clk),
    .sda_oe_n(sda_oe_n),
    .sda_out(sda_out),
    .scl(scl),
    .sda_in(sda_in)
  );
  task end_sim;
  begin
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  task hdr(input [15:0] a);
  begin
    u_mst.start;
    u_mst.dev(strap, 1'b0, k);
    u_mst.xfer(a[15:8], 1'b1, r, k);
    u_mst.xfer(a[7:0], 1'b1, r, k);
    chk({7'h0, k}, 8'h0);
  end
  endtask
  task wr(input [15:0] a, input [31:0] d, input integer n, input e);
  begin
    hdr(a);
    for (i = 0; i < n; i = i + 1)
    begin
      u_mst.xfer(d[31 - 8 * i -: 8], 1'b1, r, k);
      chk({7'h0, k}, {7'h0, e});
    end
    u_mst.stop;
    if (!e)
    begin
      u_mst.start;
      u_mst.dev(strap, 1'b1, k);
      chk({7'h0, k}, 8'h1);
      u_mst.stop;
    end
    for (i = 0; i < 3000 && program_busy !== 1'b0; i = i + 1)
      @(negedge ref_clk);
    chk({7'h0, program_busy}, 8'h0);
  end
  endtask
  task rd(input [15:0] a, input integer n);
  begin
    hdr(a);
    u_mst.start;
    u_mst.dev(strap, 1'b1, k);
    for (i = 0; i < n; i = i + 1)
    begin
      u_mst.xfer(8'hFF, i == n - 1, r, k);
      rb = {rb[55:0], r};
    end
    u_mst.stop;
  end
  endtask
  task t_straps;
    integer v;
  begin
    for (v = 7; v >= 0; v = v - 1)
    begin
      strap = v[2:0];
      u_mst.start;
      u_mst.dev(strap ^ 3'h5, 1'b1, k);
      chk({7'h0, k}, 8'h1);
      u_mst.start;
      u_mst.dev(strap, 1'b1, k);
      chk({7'h0, k}, 8'h0);
      u_mst.xfer(8'hFF, 1'b1, r, k);
      u_mst.stop;
    end
    // Straps end low, as open pins read
    u_mst.start;
    u_mst.xfer(8'h51, 1'b1, r, k);
    chk({7'h0, k}, 8'h1);
    u_mst.stop;
  end
  endtask
  task t_merge;
  begin
    wr(16'h0104, 32'h01237F80, 4, 1'b0);
    wr(16'h0102, 32'h5A000000, 1, 1'b0);
    rd(16'h0100, 8);
    for (j = 0; j < 8; j = j + 1)
      chk(rb[63 - 8 * j -: 8], 64'hFFFF5AFF01237F80 >> (56 - 8 * j));
    // One flipped stored bit must come back corrected
    u_dut.mem[14'h0041][0] = ~u_dut.mem[14'h0041][0];
    rd(16'h0104, 4);
    for (j = 0; j < 4; j = j + 1)
      chk(rb[31 - 8 * j -: 8], 32'h01237F80 >> (24 - 8 * j));
  end
  endtask
  task t_protect;
  begin
    write_protect = 1'b1;
    wr(16'h0200, 32'h0, 1, 1'b1);
    write_protect = 1'b0;
    rd(16'h0200, 1);
    chk(rb[7:0], 8'hFF);
  end
  endtask
  initial
  begin
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (8) @(negedge ref_clk);
    t_straps;
    t_merge;
    t_protect;
    end_sim;
  end
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    failures = failures + 1;
    end_sim;
  end
endmodule
